// ===== hdl/ssp_pkg.sv
/*
  Constants for the synchronous serial port: register offsets, bit positions,
  mode codes, reset values and divider reloads.
  Assumes one 50 MHz clock and byte-wide registers on a plain port.
*/
// Function
// RQ1 - slave select acts only in SPI slave mode with select control (0100)
// RQ2 - select low enables shifting and drives the serial out pin
// RQ3 - select high releases the serial out pin at once, mid-byte too
// RQ4 - select high resets SPI logic in slave mode with select control
// RQ5 - software enables select control for slave mode with edge select set
// RQ6 - SPI reset (select high or port disable) zeroes the bit counter
// RQ7 - serial out pin set as input never transmits; input still receives
// RQ8 - SPI master freezes during sleep and resumes where it stopped
// RQ9 - SPI slave shifts during sleep; 8 bits set flag and may wake
// RQ10 - device reset disables the port and aborts the transfer
// RQ11 - SPI modes 00,01,10,11 map to idle/edge 0/1,0/0,1/1,1/0
// RQ12 - I2C mode: master, slave, general call, start/stop, 7/10-bit address
// RQ13 - I2C control registers read/write; status low 6 read-only, top 2 rw
// RQ14 - address register is own address (slave) or baud reload (master)
// RQ15 - I2C receive double buffered; buffer write loads buffer and shifter
// RQ16 - status bit 7 selects slew-rate control
// RQ17 - status bit 6 enables SMBus input thresholds
// RQ18 - data/address bit: 1 after data, 0 after address, slave mode
// RQ19 - stop/start bits show last condition; cleared on reset and disable
// RQ20 - read/write bit: slave direction, master transmit in progress
// RQ21 - 10-bit slave sets address-update bit
// RQ22 - buffer-full shows received byte or transmit in progress
// RQ23 - mode field: 0-2 master clk/4,/16,/64; 3 timer/2; 4,5 slave
// RQ24 - buffer write during transfer is dropped and sets write collision
// RQ25 - slave bit counter counts from zero, byte done after eighth bit
package ssp_pkg;
  // register offsets
  localparam logic [3:0] A_BUF = 4'h0;
  localparam logic [3:0] A_CTL = 4'h1;
  localparam logic [3:0] A_STAT = 4'h2;
  localparam logic [3:0] A_CTL2 = 4'h3;
  localparam logic [3:0] A_ADR = 4'h4;
  localparam logic [3:0] A_PF = 4'h5;
  localparam logic [3:0] A_PE = 4'h6;
  localparam logic [3:0] A_PP = 4'h7;
  localparam logic [3:0] A_TRIS = 4'h8;
  // control bits
  localparam int C_WRITE_COLLISION = 7;
  localparam int C_OV = 6;
  localparam int C_EN = 5;
  localparam int C_CKP = 4;
  localparam int C_GCEN = 7;
  // status bits
  localparam int S_SMP = 7;
  localparam int S_CKE = 6;
  localparam int S_DA = 5;
  localparam int S_P = 4;
  localparam int S_S = 3;
  localparam int S_RW = 2;
  localparam int S_UA = 1;
  localparam int S_BF = 0;
  // irq flag/enable position, direction bits
  localparam int F_SSP = 3;
  localparam int T_SCK = 3;
  localparam int T_SDO = 5;
  // mode codes
  localparam logic [3:0] M_DIV4 = 4'h0;
  localparam logic [3:0] M_DIV16 = 4'h1;
  localparam logic [3:0] M_DIV64 = 4'h2;
  localparam logic [3:0] M_TMR = 4'h3;
  localparam logic [3:0] M_SS = 4'h4;
  localparam logic [3:0] M_NOSS = 4'h5;
  localparam logic [3:0] M_I2C7 = 4'h6;
  localparam logic [3:0] M_I2C10 = 4'h7;
  localparam logic [3:0] M_I2CM = 4'h8;
  localparam logic [3:0] M_I2CFW = 4'hb;
  localparam logic [3:0] M_I2C7I = 4'he;
  localparam logic [3:0] M_I2C10I = 4'hf;
  // half-period reloads (reload + 1 steps per sck edge; a step is a clock, or a timer tick in M_TMR)
  localparam logic [8:0] R_DIV4 = 9'h001;
  localparam logic [8:0] R_DIV16 = 9'h007;
  localparam logic [8:0] R_DIV64 = 9'h01f;
  localparam logic [8:0] R_TMR = 9'h000;
  // reset value, bit count and 10-bit address header
  localparam logic [7:0] TRIS_RST = 8'hff;
  localparam logic [3:0] BITS = 4'h8;
  localparam logic [4:0] TEN_HDR = 5'h1e;
endpackage

// ===== hdl/ssp_rate_div.sv
/*
  Rate divider: one-cycle tick every reload+1 counted steps while running.
  Assumes step is a one-cycle enable; stopping run parks the count.
*/
`timescale 1ns/1ps
module ssp_rate_div
  import ssp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control
  input wire logic run,
  input wire logic step,
  input wire logic [8:0] reload,
  // output
  output logic tick
);
  typedef struct packed {
    logic [8:0] cnt;
    logic tick;
  } ssp_div_t;

  ssp_div_t s;
  ssp_div_t next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (!run) begin
      // parked, not cleared: a halted master keeps its phase
      next_s.tick = 1'b0;
    end else if (step) begin
      if (s.cnt == 9'h000) begin
        next_s.cnt = reload;
        next_s.tick = 1'b1;
      end else begin
        next_s.cnt = s.cnt - 9'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
endmodule

// ===== hdl/ssp_top.sv
/*
  Synchronous serial port: SPI master/slave and I2C register set with a
  slave receive path, start/stop detection and a master bit timer.
  Assumes all pins are synchronous to clk; sck doubles as scl, sdi as sda.
*/
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module ssp_top
  import ssp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // serial pins
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic sdo_oe,
  input wire logic ss_n,
  // system
  input wire logic sleep,
  input wire logic timer_tick,
  output logic wake
);
  typedef struct packed {
    logic [7:0] buf_q;
    logic [7:0] sr;
    logic [3:0] cnt;
    logic busy;
    logic sck;
    logic serial_out_pin;
    logic sdo_oe;
    logic sck_oe;
    logic [7:0] ctl;
    logic [7:0] stat;
    logic [7:0] ctl2;
    logic [7:0] adr;
    logic [7:0] pf;
    logic [7:0] pe;
    logic [7:0] pp;
    logic [7:0] rdata;
    logic wake;
    logic psck;
    logic psda;
    logic aph;
    logic sel;
    logic [7:0] tris;
  } ssp_st_t;

  localparam ssp_st_t ST_RST = '{tris: TRIS_RST, default: '0};

  ssp_st_t s;
  ssp_st_t next_s;

  logic tick;
  logic div_run;
  logic div_step;
  logic [8:0] div_reload;

  logic [3:0] mode;
  logic en;
  logic clock_idle_level;
  logic cke;
  logic spi_m;
  logic spi_s;
  logic ss_rst;
  logic slave_act;
  logic i2c_s;
  logic i2c_m;
  logic lead;
  logic trail;
  logic samp;
  logic launch;
  logic xfer_busy;
  logic set_flag;
  logic scl_rise;
  logic start_c;
  logic stop_c;
  logic match;
  logic gcall;
  logic [7:0] rx;

  assign mode = s.ctl[3:0];
  assign en = s.ctl[C_EN];
  assign clock_idle_level = s.ctl[C_CKP];
  assign cke = s.stat[S_CKE];
  assign spi_m = en && (mode[3:2] == 2'b00); // [RQ23]
  assign spi_s = en && (mode == M_SS || mode == M_NOSS);
  assign ss_rst = en && (mode == M_SS) && ss_n; // [RQ1] [RQ4]
  assign slave_act = spi_s && !ss_rst; // [RQ2]
  assign i2c_s = en && (mode == M_I2C7 || mode == M_I2C10 ||
                        mode == M_I2C7I || mode == M_I2C10I);
  assign i2c_m = en && (mode == M_I2CM || mode == M_I2CFW); // [RQ12]

  // master clock freezes in sleep; slave edges come from the pin
  assign div_run = s.busy && (spi_m || i2c_m) && !sleep; // [RQ8]
  assign div_step = (spi_m && mode == M_TMR) ? timer_tick : 1'b1;

  always_comb begin
    div_reload = R_DIV4;
    case (mode)
      M_DIV4: div_reload = R_DIV4;
      M_DIV16: div_reload = R_DIV16;
      M_DIV64: div_reload = R_DIV64;
      M_TMR: div_reload = R_TMR;
      // fosc/(4*(n+1)) per bit, low seven bits only
      default: div_reload = {s.adr[6:0], 2'b11}; // [RQ14]
    endcase
  end

  ssp_rate_div u_div (
    .clk(clk),
    .reset_n(reset_n),
    .run(div_run),
    .step(div_step),
    .reload(div_reload),
    .tick(tick)
  );

  always_comb begin
    next_s = s;
    set_flag = 1'b0;
    lead = 1'b0;
    trail = 1'b0;
    rx = {s.sr[6:0], serial_in_pin};
    match = 1'b0;
    gcall = 1'b0;
    next_s.psck = sck_in;
    next_s.psda = serial_in_pin;
    scl_rise = !s.psck && sck_in;
    start_c = (i2c_s || i2c_m) && s.psck && sck_in && s.psda && !serial_in_pin;
    stop_c = (i2c_s || i2c_m) && s.psck && sck_in && !s.psda && serial_in_pin;
    xfer_busy = s.busy || (spi_s && s.cnt != 4'h0) ||
                (i2c_s && s.stat[S_RW] && s.stat[S_BF]);

    // register reads, data one cycle later
    next_s.rdata = 8'h00;
    if (rd) begin
      case (addr)
        A_BUF: next_s.rdata = s.buf_q;
        A_CTL: next_s.rdata = s.ctl;
        A_STAT: next_s.rdata = s.stat;
        A_CTL2: next_s.rdata = s.ctl2;
        A_ADR: next_s.rdata = s.adr;
        A_PF: next_s.rdata = s.pf;
        A_PE: next_s.rdata = s.pe;
        A_PP: next_s.rdata = s.pp;
        A_TRIS: next_s.rdata = s.tris;
        default: next_s.rdata = 8'h00;
      endcase
      if (addr == A_BUF) begin
        next_s.stat[S_BF] = 1'b0;
      end
    end

    // register writes; hardware sets below take priority
    if (wr) begin
      case (addr)
        A_CTL: next_s.ctl = wdata; // [RQ13]
        A_STAT: next_s.stat[7:6] = wdata[7:6]; // [RQ13] [RQ16] [RQ17]
        A_CTL2: next_s.ctl2 = wdata;
        A_ADR: begin
          next_s.adr = wdata;
          next_s.stat[S_UA] = 1'b0;
        end
        A_PF: next_s.pf = wdata;
        A_PE: next_s.pe = wdata;
        A_PP: next_s.pp = wdata;
        A_TRIS: next_s.tris = wdata;
        A_BUF: begin
          if (xfer_busy) begin
            next_s.ctl[C_WRITE_COLLISION] = 1'b1; // [RQ24]
          end else begin
            next_s.buf_q = wdata; // [RQ15]
            next_s.sr = wdata;
            next_s.cnt = 4'h0;
            if (cke) begin
              next_s.serial_out_pin = wdata[7];
            end
            if (spi_m || i2c_m) begin
              next_s.busy = 1'b1;
            end
            if (i2c_m || i2c_s) begin
              next_s.stat[S_BF] = 1'b1; // [RQ22]
            end
            if (i2c_m) begin
              next_s.stat[S_RW] = 1'b1; // [RQ20]
            end
          end
        end
        default: next_s.tris = next_s.tris;
      endcase
    end

    // SPI edge detection, one framework for master and slave
    // a tick already in flight is dropped in sleep; the divider reloads, so the edge only comes late
    if (spi_m && s.busy && tick && !sleep) begin // [RQ8]
      lead = (s.sck == clock_idle_level);
      trail = !lead;
      next_s.sck = !s.sck;
    end else if (slave_act && sck_in != s.psck) begin
      lead = (s.psck == clock_idle_level);
      trail = !lead;
    end
    // edge select 1 samples on the leading edge, 0 on the trailing
    samp = cke ? lead : trail; // [RQ11]
    launch = cke ? trail : lead;

    if (samp) begin
      next_s.sr = rx;
      next_s.cnt = s.cnt + 4'h1; // [RQ25]
      if (s.cnt == BITS - 4'h1) begin
        set_flag = 1'b1; // [RQ9]
        if (spi_s && s.stat[S_BF]) begin
          // unread byte kept; new one dropped
          next_s.ctl[C_OV] = 1'b1;
        end else begin
          next_s.buf_q = rx;
          next_s.stat[S_BF] = 1'b1;
        end
        if (spi_s) begin
          next_s.cnt = 4'h0; // [RQ25]
        end
      end
    end
    if (launch) begin
      next_s.serial_out_pin = s.sr[7];
    end
    if (spi_m && trail && next_s.cnt == BITS) begin
      next_s.busy = 1'b0;
      next_s.cnt = 4'h0;
    end
    if (spi_m && !s.busy) begin
      next_s.sck = clock_idle_level;
    end

    // SPI reset: select high or port off zeroes the counter
    if (ss_rst || !en) begin
      next_s.cnt = 4'h0; // [RQ6] [RQ4]
      next_s.busy = 1'b0;
      next_s.sck = clock_idle_level;
    end

    // I2C slave receive
    if (start_c) begin
      next_s.stat[S_S] = 1'b1; // [RQ19]
      next_s.stat[S_P] = 1'b0;
      next_s.cnt = 4'h0;
      next_s.aph = 1'b1;
      next_s.sel = 1'b0;
      if (i2c_s && mode[3]) begin
        set_flag = 1'b1; // [RQ12]
      end
    end else if (stop_c) begin
      next_s.stat[S_P] = 1'b1; // [RQ19]
      next_s.stat[S_S] = 1'b0;
      next_s.sel = 1'b0;
      if (i2c_s) begin
        next_s.stat[S_RW] = 1'b0; // [RQ20]
      end
      if (i2c_s && mode[3]) begin
        set_flag = 1'b1;
      end
    end else if (i2c_s && scl_rise) begin
      if (s.cnt == BITS) begin
        // ninth clock: acknowledge slot, skip it
        next_s.cnt = 4'h0;
      end else begin
        next_s.sr = rx;
        next_s.cnt = s.cnt + 4'h1;
      end
      if (s.cnt == BITS - 4'h1) begin
        if (s.aph) begin
          gcall = s.ctl2[C_GCEN] && rx == 8'h00; // [RQ12]
          if (mode[0]) begin
            match = rx[7:3] == TEN_HDR && rx[2:1] == s.adr[2:1];
          end else begin
            match = rx[7:1] == s.adr[7:1];
          end
          next_s.aph = 1'b0;
          if (match || gcall) begin
            next_s.sel = 1'b1;
            next_s.stat[S_DA] = 1'b0; // [RQ18]
            next_s.stat[S_RW] = rx[0] && !gcall; // [RQ20]
            next_s.stat[S_UA] = mode[0]; // [RQ21]
          end
        end else if (s.sel) begin
          next_s.stat[S_DA] = 1'b1; // [RQ18]
        end
        if ((s.aph && (match || gcall)) || (!s.aph && s.sel)) begin
          set_flag = 1'b1;
          if (s.stat[S_BF] || s.ctl[C_OV]) begin
            next_s.ctl[C_OV] = 1'b1;
          end else begin
            next_s.buf_q = rx; // [RQ15]
            next_s.stat[S_BF] = 1'b1;
          end
        end
      end
    end

    // I2C master: bit timer from the baud reload, no pin drive
    if (i2c_m && s.busy && tick) begin
      next_s.cnt = s.cnt + 4'h1;
      if (s.cnt == BITS - 4'h1) begin
        next_s.busy = 1'b0;
        next_s.cnt = 4'h0;
        next_s.stat[S_RW] = 1'b0; // [RQ20]
        next_s.stat[S_BF] = 1'b0; // [RQ22]
        set_flag = 1'b1;
      end
    end

    if (!en) begin
      next_s.stat[S_P] = 1'b0; // [RQ19]
      next_s.stat[S_S] = 1'b0;
      next_s.aph = 1'b0;
      next_s.sel = 1'b0;
    end

    // event beats a same-cycle software clear
    if (set_flag) begin
      next_s.pf[F_SSP] = 1'b1;
    end

    // pin drivers; direction bit set to input blocks transmit
    // stored direction bits, so the enables lag a write exactly like a mode change
    next_s.sdo_oe = (spi_m || (spi_s && !ss_rst)) &&
                    !s.tris[T_SDO]; // [RQ2] [RQ3] [RQ7]
    next_s.sck_oe = spi_m && !s.tris[T_SCK];
    next_s.wake = s.pf[F_SSP] && s.pe[F_SSP]; // [RQ9]
  end

  // reset leaves the port disabled, transfer dropped
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= ST_RST; // [RQ10]
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign sck_out = s.sck;
  assign sck_oe = s.sck_oe;
  assign serial_out_pin = s.serial_out_pin;
  assign sdo_oe = s.sdo_oe;
  assign wake = s.wake;
endmodule

// ===== verif/ssp_top_assertions.sv
/*
  Port-level checker for the serial port, with a register mirror.
  Assumes it is bound to ssp_top and sees its ports only.
*/
`timescale 1ns/1ps
module ssp_checker
  import ssp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // pins and system
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic sdo_oe,
  input wire logic ss_n,
  input wire logic sleep,
  input wire logic wake
);
  logic [7:0] ctl, tris, adr, pe, st;
  logic mst;
  logic slv;
  // mirror of software writes; hardware-set control bits are not tracked
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl <= 8'h00;
      tris <= TRIS_RST;
      adr <= 8'h00;
      pe <= 8'h00;
      st <= 8'h00;
    end else if (wr) begin
      if (addr == A_CTL) ctl <= wdata;
      if (addr == A_TRIS) tris <= wdata;
      if (addr == A_ADR) adr <= wdata;
      if (addr == A_PE) pe <= wdata;
      if (addr == A_STAT) st <= wdata;
    end
  end
  assign mst = ctl[C_EN] && (ctl[3:0] <= M_TMR) && !tris[T_SCK];
  assign slv = ctl[5:0] == 6'h24;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_rd_quiet; !$past(rd) |-> rdata == 8'h00; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside read cycle");
  property p_adr; rd && addr == A_ADR |=> rdata == adr; endproperty
  a_adr: assert property (p_adr) else $error("address register readback");
  property p_stat; rd && addr == A_STAT |=> rdata[7:6] == st[7:6]; endproperty
  a_stat: assert property (p_stat) else $error("status top bits readback");
  property p_ss_drive; slv && !ss_n && !tris[T_SDO] |=> sdo_oe; endproperty
  a_ss_drive: assert property (p_ss_drive) else $error("selected slave not driving");
  property p_ss_off; slv && ss_n |=> !sdo_oe; endproperty
  a_ss_off: assert property (p_ss_off) else $error("deselected slave drives");
  property p_tris; tris[T_SDO] |=> !sdo_oe; endproperty
  a_tris: assert property (p_tris) else $error("serial out driven as input");
  property p_sck_on; mst |=> sck_oe; endproperty
  a_sck_on: assert property (p_sck_on) else $error("master clock not driven");
  property p_sck_off; !mst |=> !sck_oe; endproperty
  a_sck_off: assert property (p_sck_off) else $error("clock driven outside master");
  // ctl compared two back because sck_out lags a control write
  property p_sleep; sleep && $past(sleep) && ctl == $past(ctl, 2) |-> $stable(sck_out); endproperty
  a_sleep: assert property (p_sleep) else $error("master clock moved in sleep");
  property p_wake; !pe[F_SSP] && !$past(pe[F_SSP]) |-> !wake; endproperty
  a_wake: assert property (p_wake) else $error("wake while masked");
  c_slave: cover property (slv && !ss_n && sdo_oe);
  c_sleep: cover property (sleep && sck_oe);
  c_wake: cover property (wake && sleep);
endmodule
bind ssp_top ssp_checker i_ssp_checker (
  .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .sck_out(sck_out), .sck_oe(sck_oe), .sdo_oe(sdo_oe), .ss_n(ss_n),
  .sleep(sleep), .wake(wake)
);

// ===== verif/ssp_far_end.sv
/*
  Far side: SPI master in any bus mode, and I2C start/stop maker.
  Assumes pins change only after rising edges of clk.
*/
`timescale 1ns/1ps
module ssp_far_end (
  // clock
  input wire logic clk,
  // pins
  input wire logic miso,
  output logic sck,
  output logic mosi,
  output logic ss_n
);
  logic clock_idle_level;
  logic cke;
  logic [7:0] got;
  initial begin
    sck = 1'b0;
    mosi = 1'b1;
    ss_n = 1'b1;
    clock_idle_level = 1'b0;
    cke = 1'b1;
    got = 8'h00;
  end
  task automatic half();
    repeat (8) @(posedge clk);
  endtask
  // n under 8 ends the frame mid-byte, then raises select; sck stands still between frames
  task automatic xfer(input logic [7:0] d, input int n);
    // settle the idle level while still deselected, so no false edge
    sck <= clock_idle_level;
    half();
    ss_n <= 1'b0;
    half();
    for (int i = 7; i > 7 - n; i--) begin
      if (cke) begin
        mosi <= d[i];
        half();
        sck <= !clock_idle_level;
        got <= {got[6:0], miso};
        half();
        sck <= clock_idle_level;
      end else begin
        sck <= !clock_idle_level;
        mosi <= d[i];
        half();
        sck <= clock_idle_level;
        got <= {got[6:0], miso};
        half();
      end
    end
    ss_n <= 1'b1;
    mosi <= !mosi;
    half();
  endtask
  // start: data falls, clock high; stop: data rises
  task automatic cond(input logic stop);
    sck <= 1'b1;
    mosi <= !stop;
    half();
    mosi <= stop;
    half();
  endtask
endmodule

// ===== verif/ssp_top_tb.sv
/*
  Bench for the serial port: register model, SPI slave in four modes,
  select reset and collision, master in sleep, reset abort, I2C conditions.
  Assumes the far-end model and the bound checker.
*/
`timescale 1ns/1ps
module ssp_top_tb;
  import ssp_pkg::*;
  logic clk, reset_n, wr, rd, sleep, timer_tick, loop, serial_in_pin, miso;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, tx, rx, ctl;
  logic sck_out, sck_oe, serial_out_pin, sdo_oe, wake, fsck, fmosi, fss_n;
  logic [7:0] m [0:15];
  logic [3:0] rw [4] = '{A_STAT, A_CTL2, A_ADR, A_PP};
  int n_fail = 0;
  int compares = 0;
  // one-wire loopback in master mode, serial out to serial in
  assign serial_in_pin = loop ? serial_out_pin : fmosi;
  // released serial out shows the inverse, not a held level
  assign miso = sdo_oe ? serial_out_pin : !serial_out_pin;
  ssp_top i_ssp_top (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sck_in(fsck), .sck_out(sck_out), .sck_oe(sck_oe), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .sdo_oe(sdo_oe), .ss_n(fss_n), .sleep(sleep),
    .timer_tick(timer_tick), .wake(wake)
  );
  ssp_far_end i_ssp_far_end (.clk(clk), .miso(miso), .sck(fsck), .mosi(fmosi), .ss_n(fss_n));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) timer_tick <= 1'($urandom_range(1));
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic complete_run();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    complete_run();
  end
  initial begin
    reset_n = 1'b0;
    {wr, rd, sleep, loop} = 4'h0;
    addr = 4'h0;
    wdata = 8'h00;
    void'($urandom(81));
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 16; a++) begin
      m[a] = (a == 8) ? TRIS_RST : 8'h00;
      rchk(4'(a), m[a]);
    end
    foreach (rw[i]) begin
      tx = 8'($urandom);
      wreg(rw[i], tx);
      m[rw[i]] = (rw[i] == A_STAT) ? {tx[7:6], 6'h00} : tx;
      rchk(rw[i], m[rw[i]]);
    end
    wreg(A_TRIS, 8'hdf);
    wreg(A_PE, 8'h08);
    for (int k = 0; k < 4; k++) begin
      i_ssp_far_end.clock_idle_level = k[1];
      i_ssp_far_end.cke = !k[0];
      ctl = {3'b001, k[1], M_SS};
      wreg(A_STAT, {1'b0, !k[0], 6'h00});
      wreg(A_CTL, ctl);
      tx = 8'($urandom);
      rx = 8'($urandom);
      wreg(A_BUF, tx);
      sleep <= k[0];
      i_ssp_far_end.xfer(rx, 8);
      chk({7'h00, wake}, 8'h01);
      sleep <= 1'b0;
      chk(i_ssp_far_end.got, tx);
      rchk(A_PF, 8'h08);
      rchk(A_BUF, rx);
      wreg(A_PF, 8'h00);
    end
    rx = 8'($urandom);
    fork
      i_ssp_far_end.xfer(~rx, 5);
      begin
        repeat (40) @(posedge clk);
        wreg(A_BUF, 8'h55);
      end
    join
    i_ssp_far_end.xfer(rx, 8);
    rchk(A_BUF, rx);
    rchk(A_CTL, {1'b1, ctl[6:0]});
    wreg(A_PF, 8'h00);
    wreg(A_CTL, 8'h20);
    wreg(A_STAT, 8'h40);
    wreg(A_TRIS, 8'hd7);
    loop <= 1'b1;
    tx = 8'($urandom);
    wreg(A_BUF, tx);
    repeat (8) @(posedge clk);
    sleep <= 1'b1;
    repeat (40) @(posedge clk);
    rchk(A_PF, 8'h00);
    sleep <= 1'b0;
    repeat (60) @(posedge clk);
    rchk(A_PF, 8'h08);
    rchk(A_BUF, tx);
    wreg(A_BUF, 8'h3c);
    repeat (6) @(posedge clk);
    reset_n <= 1'b0;
    @(posedge clk);
    reset_n <= 1'b1;
    loop <= 1'b0;
    @(posedge clk);
    #1;
    chk({6'h00, sck_oe, sdo_oe}, 8'h00);
    rchk(A_CTL, 8'h00);
    wreg(A_CTL, 8'h26);
    i_ssp_far_end.cond(1'b0);
    rchk(A_STAT, 8'h08);
    i_ssp_far_end.cond(1'b1);
    rchk(A_STAT, 8'h10);
    wreg(A_CTL, 8'h06);
    // the disable clear lands one cycle after the control write
    @(posedge clk);
    rchk(A_STAT, 8'h00);
    wreg(A_ADR, 8'h01);
    wreg(A_CTL, 8'h28);
    wreg(A_BUF, 8'ha5);
    rchk(A_STAT, 8'h05);
    repeat (80) @(posedge clk);
    rchk(A_STAT, 8'h00);
    rchk(A_PF, 8'h08);
    complete_run();
  end
endmodule
